/* File: logic/cpu_bit_exec.sv */
// Bit, shift, flag, load/store and miscellaneous execution unit on AHB-Lite.
// Assumes one AHB-Lite master doing single word transfers; memories are local arrays.
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module cpu_bit_exec (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output exec_pkg::event_s events,
    input wire logic [7:0] prog_byte,
    output logic [15:0] prog_addr
);
    import exec_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01
    } state_e;

    logic [7:0] data_mem [MEM_WORDS];
    logic [7:0] io_mem [IO_WORDS];
    cmd_s cmd_reg;
    logic [7:0] opnd_reg;
    logic [7:0] flags_reg;
    logic [7:0] result_reg;
    logic [15:0] ptr_reg [3];
    state_e state_reg;
    logic [1:0] count_reg;
    logic [1:0] count_next;
    event_s events_reg;
    logic ap_write_reg;
    logic ap_read_reg;
    logic [7:0] ap_addr_reg;
    logic [7:0] flags_next;
    logic [7:0] alu_out;
    logic [15:0] ptr_new;
    logic [15:0] mem_addr;

    // Address phase capture; every access is answered in one data phase cycle.
    wire ap_valid = hsel && hready && htrans[1];
    wire bus_cmd_wr = ap_write_reg && (ap_addr_reg == CMD_OFS) && (state_reg == ST_IDLE);
    wire busy = (state_reg == ST_RUN);
    wire op_e cur_op = op_e'(cmd_reg.op);
    wire [7:0] rd_val = opnd_reg;
    wire [2:0] bsel = cmd_reg.bit_sel;
    wire [1:0] psel = cmd_reg.ptr;
    wire [15:0] ptr_cur = ptr_reg[psel];
    wire ptr_ok = (psel != 2'b11);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_write_reg <= 1'b0;
            ap_read_reg <= 1'b0;
            ap_addr_reg <= 8'h00;
        end else begin
            ap_write_reg <= ap_valid && hwrite;
            ap_read_reg <= ap_valid && !hwrite;
            ap_addr_reg <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Number of cycles each operation occupies.
    function automatic logic [1:0] op_cycles(input logic [4:0] op);
        case (op_e'(op))
            OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_MEM_READ_INDIRECT, OP_MEM_READ_OFFSET,
            OP_MEM_READ_DIRECT, OP_MEM_WRITE_INDIRECT, OP_MEM_WRITE_OFFSET,
            OP_MEM_WRITE_DIRECT: op_cycles = CYC_TWO;
            OP_PROGRAM_MEMORY_FETCH: op_cycles = CYC_THREE;
            default: op_cycles = CYC_ONE;
        endcase
    endfunction

    // Sequencer: a command write starts a run of op_cycles cycles; the work lands in the last one.
    wire last_cycle = busy && (count_reg == CYC_ONE);
    wire [1:0] start_count = op_cycles(hwdata[4:0]);
    assign count_next = bus_cmd_wr ? start_count : (busy ? count_reg - CYC_ONE : count_reg);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= ST_IDLE;
            count_reg <= 2'h0;
            cmd_reg <= '0;
        end else begin
            count_reg <= count_next;
            if (bus_cmd_wr) begin
                cmd_reg <= cmd_s'(hwdata[27:0]);
                state_reg <= ST_RUN;
            end else if (last_cycle) begin
                state_reg <= ST_IDLE;
            end
        end
    end

    // Pointer update and effective address; pre-decrement addresses the new value.
    assign ptr_new = (cmd_reg.mode == MODE_POST_INC) ? ptr_cur + 16'h0001 :
                     (cmd_reg.mode == MODE_PRE_DEC) ? ptr_cur - 16'h0001 : ptr_cur; // [RQ12] [RQ13]
    wire is_indirect = (cur_op == OP_MEM_READ_INDIRECT) || (cur_op == OP_MEM_WRITE_INDIRECT);
    wire is_offset = (cur_op == OP_MEM_READ_OFFSET) || (cur_op == OP_MEM_WRITE_OFFSET);
    wire is_direct = (cur_op == OP_MEM_READ_DIRECT) || (cur_op == OP_MEM_WRITE_DIRECT);
    assign mem_addr = is_offset ? ptr_cur + {8'h00, cmd_reg.field} :          // [RQ14] [RQ18]
                      is_direct ? {8'h00, cmd_reg.field} :                     // [RQ15] [RQ19]
                      (cmd_reg.mode == MODE_PRE_DEC) ? ptr_new : ptr_cur;      // [RQ13] [RQ17]
    wire [4:0] mem_idx = mem_addr[4:0];
    wire [2:0] io_idx = cmd_reg.field[2:0];
    wire is_load = (cur_op == OP_MEM_READ_INDIRECT) || (cur_op == OP_MEM_READ_OFFSET) ||
                   (cur_op == OP_MEM_READ_DIRECT);
    wire is_store = (cur_op == OP_MEM_WRITE_INDIRECT) || (cur_op == OP_MEM_WRITE_OFFSET) ||
                    (cur_op == OP_MEM_WRITE_DIRECT);
    wire ptr_upd = is_indirect && ptr_ok && (cmd_reg.mode != MODE_PLAIN);
    wire fetch_inc = (cur_op == OP_PROGRAM_MEMORY_FETCH) && (cmd_reg.mode == MODE_POST_INC);
    assign prog_addr = ptr_reg[PTR_Z]; // [RQ20]

    // Shift, rotate and bit results with their flags.
    always_comb begin
        alu_out = rd_val;
        flags_next = flags_reg;
        case (cur_op)
            OP_LOGIC_LEFT_SHIFT: begin
                alu_out = {rd_val[6:0], 1'b0}; // [RQ3]
                flags_next[FLAG_C] = rd_val[7];
            end
            OP_LOGIC_RIGHT_SHIFT: begin
                alu_out = {1'b0, rd_val[7:1]}; // [RQ4]
                flags_next[FLAG_C] = rd_val[0];
            end
            OP_ROTATE_LEFT_CARRY: begin
                alu_out = {rd_val[6:0], flags_reg[FLAG_C]}; // [RQ5]
                flags_next[FLAG_C] = rd_val[7];
            end
            OP_ROTATE_RIGHT_CARRY: begin
                alu_out = {flags_reg[FLAG_C], rd_val[7:1]}; // [RQ6]
                flags_next[FLAG_C] = rd_val[0];
            end
            OP_ARITH_RIGHT_SHIFT: begin
                alu_out = {rd_val[7], rd_val[7:1]}; // [RQ7] [RQ8]
                flags_next[FLAG_C] = rd_val[0];
            end
            OP_FLAG_SET: flags_next[bsel] = 1'b1; // [RQ9]
            OP_FLAG_CLEAR: flags_next[bsel] = 1'b0; // [RQ9]
            OP_FLAG_T_CAPTURE: flags_next[FLAG_T] = rd_val[bsel]; // [RQ10]
            OP_FLAG_T_DEPOSIT: alu_out[bsel] = flags_reg[FLAG_T]; // [RQ11]
            default: alu_out = rd_val;
        endcase
        if (cur_op inside {OP_LOGIC_LEFT_SHIFT, OP_LOGIC_RIGHT_SHIFT, OP_ROTATE_LEFT_CARRY,
                           OP_ROTATE_RIGHT_CARRY, OP_ARITH_RIGHT_SHIFT}) begin
            flags_next[FLAG_Z] = (alu_out == 8'h00); // [RQ3] [RQ4] [RQ5] [RQ6] [RQ7]
            flags_next[FLAG_N] = alu_out[7];
            flags_next[FLAG_V] = alu_out[7] ^ flags_next[FLAG_C];
        end
    end

    // Result, flags and pointers land in the last cycle of a run.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_reg <= FLAGS_RESET;
            result_reg <= 8'h00;
            opnd_reg <= 8'h00;
            ptr_reg <= '{16'h0000, 16'h0000, 16'h0000};
        end else begin
            if (ap_write_reg && (ap_addr_reg == OPND_OFS) && !busy) begin
                opnd_reg <= hwdata[7:0];
            end
            if (ap_write_reg && (ap_addr_reg == FLAGS_OFS) && !busy) begin
                flags_reg <= hwdata[7:0];
            end else if (last_cycle) begin
                flags_reg <= flags_next;
            end
            if (last_cycle) begin
                if (is_load) begin
                    result_reg <= data_mem[mem_idx]; // [RQ12] [RQ14] [RQ15]
                end else if (cur_op == OP_PROGRAM_MEMORY_FETCH) begin
                    result_reg <= prog_byte; // [RQ20]
                end else if (cur_op != OP_SET_IO_BIT && cur_op != OP_CLEAR_IO_BIT && !is_store) begin
                    result_reg <= alu_out;
                end
            end
            for (int p = 0; p < 3; p++) begin
                if (ap_write_reg && (ap_addr_reg == PTRX_OFS + 8'(4 * p)) && !busy) begin
                    ptr_reg[p] <= hwdata[15:0];
                end else if (last_cycle && ptr_upd && (psel == 2'(p))) begin
                    ptr_reg[p] <= ptr_new; // [RQ12] [RQ13] [RQ16] [RQ17]
                end else if (last_cycle && fetch_inc && (p == 2)) begin
                    ptr_reg[p] <= ptr_reg[p] + 16'h0001; // [RQ20]
                end
            end
        end
    end

    // Data memory and I/O space; stores and I/O bit changes occur in the last cycle.
    wire bus_mem_wr = ap_write_reg && (ap_addr_reg >= MEM_BASE_OFS) && !busy;
    always_ff @(posedge hclk) begin
        if (last_cycle && is_store) begin
            data_mem[mem_idx] <= opnd_reg; // [RQ16] [RQ17] [RQ18] [RQ19]
        end else if (bus_mem_wr) begin
            data_mem[ap_addr_reg[6:2]] <= hwdata[7:0];
        end
        if (last_cycle && cur_op == OP_SET_IO_BIT) begin
            io_mem[io_idx][bsel] <= 1'b1; // [RQ1]
        end else if (last_cycle && cur_op == OP_CLEAR_IO_BIT) begin
            io_mem[io_idx][bsel] <= 1'b0; // [RQ2]
        end else if (bus_mem_wr && ap_addr_reg[6:5] == 2'b11) begin
            io_mem[ap_addr_reg[4:2]] <= hwdata[15:8];
        end
    end

    // One-cycle pulses for sleep, watchdog and break.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            events_reg <= '0;
        end else begin
            events_reg.sleep <= last_cycle && (cur_op == OP_SLEEP); // [RQ21]
            events_reg.watchdog <= last_cycle && (cur_op == OP_WATCHDOG_RESTART); // [RQ22]
            events_reg.brk <= last_cycle && (cur_op == OP_BREAK); // [RQ23]
        end
    end
    assign events = events_reg;

    // Read data mux: registers, then the memory window.
    wire [31:0] status_word = {28'h0000000, count_reg, 1'b0, busy};
    wire [31:0] mem_word = {16'h0000, io_mem[ap_addr_reg[4:2]], data_mem[ap_addr_reg[6:2]]};
    wire [31:0] reg_word = (ap_addr_reg == CMD_OFS) ? 32'(cmd_reg) :
                           (ap_addr_reg == OPND_OFS) ? {24'h000000, opnd_reg} :
                           (ap_addr_reg == FLAGS_OFS) ? {24'h000000, flags_reg} :
                           (ap_addr_reg == RESULT_OFS) ? {24'h000000, result_reg} :
                           (ap_addr_reg == STATUS_OFS) ? status_word :
                           (ap_addr_reg == PTRX_OFS) ? {16'h0000, ptr_reg[0]} :
                           (ap_addr_reg == PTRY_OFS) ? {16'h0000, ptr_reg[1]} :
                           (ap_addr_reg == PTRZ_OFS) ? {16'h0000, ptr_reg[2]} : 32'h00000000;
    assign hrdata = !ap_read_reg ? 32'h00000000 :
                    (ap_addr_reg >= MEM_BASE_OFS) ? mem_word : reg_word;

    // Checks on cycle counts, results, flag effects, pointer update and pulse length.
    sequence s_start_two;
        bus_cmd_wr && (start_count == CYC_TWO);
    endsequence
    a_two_cycle_run: assert property (@(posedge hclk) disable iff (!hresetn)
        s_start_two |=> busy ##1 (busy && last_cycle) ##1 !busy) // [RQ1]
        else $error("two-cycle operation length wrong");
    a_fetch_three: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_cmd_wr && hwdata[4:0] == OP_PROGRAM_MEMORY_FETCH |=> busy [*3] ##1 !busy) // [RQ20]
        else $error("program fetch not three cycles");
    a_shift_left_val: assert property (@(posedge hclk) disable iff (!hresetn)
        last_cycle && cur_op == OP_LOGIC_LEFT_SHIFT |=>
        result_reg == {$past(opnd_reg[6:0]), 1'b0} && flags_reg[FLAG_C] == $past(opnd_reg[7])) // [RQ3]
        else $error("left shift result wrong");
    a_asr_sign_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        last_cycle && cur_op == OP_ARITH_RIGHT_SHIFT |=> result_reg[7] == $past(opnd_reg[7])) // [RQ8]
        else $error("arith shift lost sign");
    a_rotate_right_c: assert property (@(posedge hclk) disable iff (!hresetn)
        last_cycle && cur_op == OP_ROTATE_RIGHT_CARRY |=>
        result_reg[7] == $past(flags_reg[FLAG_C]) && flags_reg[FLAG_C] == $past(opnd_reg[0])) // [RQ6]
        else $error("rotate right carry wrong");
    a_capture_only_t: assert property (@(posedge hclk) disable iff (!hresetn)
        last_cycle && cur_op == OP_FLAG_T_CAPTURE && !(ap_write_reg && ap_addr_reg == FLAGS_OFS) |=>
        (flags_reg & 8'hbf) == ($past(flags_reg) & 8'hbf)) // [RQ10]
        else $error("bit capture touched other flags");
    a_store_keeps_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        last_cycle && (is_store || is_load) |=> $stable(flags_reg)) // [RQ12]
        else $error("memory op changed flags");
    a_predec_ptr: assert property (@(posedge hclk) disable iff (!hresetn)
        last_cycle && ptr_upd && cmd_reg.mode == MODE_PRE_DEC && psel == PTR_Y |=>
        ptr_reg[1] == $past(ptr_reg[1]) - 16'h0001) // [RQ13]
        else $error("pre-decrement pointer wrong");
    a_watchdog_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
        events_reg.watchdog |=> !events_reg.watchdog) // [RQ22]
        else $error("watchdog pulse too long");
endmodule

/* File: logic/exec_pkg.sv */
// Constants, enumerations and carrier types for the bit and load/store execution unit.
// Assumes a single core clock and an AHB-Lite master that issues single word transfers.
// Summary of operation
// (RQ1) Set I/O bit forces addressed bit to one, flags kept, two cycles.
// (RQ2) Clear I/O bit forces addressed bit to zero, flags kept, two cycles.
// (RQ3) Left shift moves bits up, zero into bit 0, updates Z C N V, one cycle.
// (RQ4) Right shift moves bits down, zero into bit 7, updates Z C N V.
// (RQ5) Rotate left takes old carry into bit 0, old bit 7 to carry.
// (RQ6) Rotate right takes old carry into bit 7, old bit 0 to carry.
// (RQ7) Arithmetic right shift copies each upper bit down, updates Z C N V, one cycle.
// (RQ8) Arithmetic right shift keeps bit 7 so the sign survives.
// (RQ9) Each flag has its own set and clear, touching only that flag, one cycle.
// (RQ10) Bit capture copies a register bit into T only, one cycle.
// (RQ11) Bit deposit writes T into a register bit, no flag change, one cycle.
// (RQ12) Indirect load reads at X, Y or Z, optional post-increment, two cycles.
// (RQ13) Pre-decrement load lowers the pointer first, then reads, two cycles.
// (RQ14) Offset load reads at Y or Z plus offset, pointer kept, two cycles.
// (RQ15) Direct load reads immediate address into a register, two cycles.
// (RQ16) Indirect store writes at X, Y or Z, optional post-increment, two cycles.
// (RQ17) Pre-decrement store lowers the pointer first, then writes, two cycles.
// (RQ18) Offset store writes at Y or Z plus offset, pointer kept, two cycles.
// (RQ19) Direct store writes a register to immediate address, two cycles.
// (RQ20) Program memory fetch reads byte at Z, optional increment, three cycles.
// (RQ21) Sleep issues in one cycle without flag change and signals sleep logic.
// (RQ22) Watchdog restart takes one cycle, no flag change, pulses watchdog.
// (RQ23) Break only signals debug logic and changes no flags.
package exec_pkg;
    // Register map, byte addresses.
    localparam logic [7:0] CMD_OFS = 8'h00;
    localparam logic [7:0] OPND_OFS = 8'h04;
    localparam logic [7:0] FLAGS_OFS = 8'h08;
    localparam logic [7:0] RESULT_OFS = 8'h0c;
    localparam logic [7:0] STATUS_OFS = 8'h10;
    localparam logic [7:0] PTRX_OFS = 8'h14;
    localparam logic [7:0] PTRY_OFS = 8'h18;
    localparam logic [7:0] PTRZ_OFS = 8'h1c;
    localparam logic [7:0] MEM_BASE_OFS = 8'h80;
    localparam int MEM_WORDS = 32;
    localparam int IO_WORDS = 8;
    // Flag positions in the status flags byte.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    // Cycle counts.
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    // Operation codes, field cmd[4:0].
    typedef enum logic [4:0] {
        OP_NOP = 5'b00000,
        OP_SET_IO_BIT = 5'b00001,
        OP_CLEAR_IO_BIT = 5'b00010,
        OP_LOGIC_LEFT_SHIFT = 5'b00011,
        OP_LOGIC_RIGHT_SHIFT = 5'b00100,
        OP_ROTATE_LEFT_CARRY = 5'b00101,
        OP_ROTATE_RIGHT_CARRY = 5'b00110,
        OP_ARITH_RIGHT_SHIFT = 5'b00111,
        OP_FLAG_SET = 5'b01000,
        OP_FLAG_CLEAR = 5'b01001,
        OP_FLAG_T_CAPTURE = 5'b01010,
        OP_FLAG_T_DEPOSIT = 5'b01011,
        OP_MEM_READ_INDIRECT = 5'b01100,
        OP_MEM_READ_OFFSET = 5'b01101,
        OP_MEM_READ_DIRECT = 5'b01110,
        OP_MEM_WRITE_INDIRECT = 5'b01111,
        OP_MEM_WRITE_OFFSET = 5'b10000,
        OP_MEM_WRITE_DIRECT = 5'b10001,
        OP_PROGRAM_MEMORY_FETCH = 5'b10010,
        OP_SLEEP = 5'b10011,
        OP_WATCHDOG_RESTART = 5'b10100,
        OP_BREAK = 5'b10101
    } op_e;
    // Pointer selection and indirect addressing mode.
    typedef enum logic [1:0] {
        PTR_X = 2'b00,
        PTR_Y = 2'b01,
        PTR_Z = 2'b10
    } ptr_e;
    typedef enum logic [1:0] {
        MODE_PLAIN = 2'b00,
        MODE_POST_INC = 2'b01,
        MODE_PRE_DEC = 2'b10
    } mode_e;
    // Command word: operation, bit index, pointer, mode, register operand, 8-bit field.
    typedef struct packed {
        logic [7:0] field;
        logic [7:0] operand;
        logic [1:0] mode;
        logic [1:0] ptr;
        logic [2:0] bit_sel;
        logic [4:0] op;
    } cmd_s;
    // Side effects that leave the unit.
    typedef struct packed {
        logic sleep;
        logic watchdog;
        logic brk;
    } event_s;
endpackage

/* File: verif/prog_mem_model.sv */
// Program memory model that answers the fetch port with a byte derived from its address.
// Assumes the fetch port samples the byte in the same clock, so the answer is combinational.
`timescale 1ns/1ps
module prog_mem_model (
    input wire logic [15:0] addr,
    output logic [7:0] data
);
    // Addresses with the same high byte give distinct bytes, so a wrong low byte of Z shows up as a wrong byte.
    assign data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the bit and load/store execution unit, driven over AHB-Lite.
// Assumes zero wait states are possible but still waits on hready under a bound.
`timescale 1ns/1ps
module tb;
    import exec_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    event_s events;
    logic [7:0] prog_byte;
    logic [15:0] prog_addr;
    int miscompares = 0;
    int cmp_count = 0;
    int ev_s = 0, ev_w = 0, ev_b = 0;

    // Clock of 50 ns period.
    always #25 hclk = ~hclk;

    // The slave's hreadyout is the bus hready.
    cpu_bit_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .events(events), .prog_byte(prog_byte), .prog_addr(prog_addr));
    prog_mem_model pm_u (.addr(prog_addr), .data(prog_byte));

    // Count the pulses on each side-effect line.
    always @(posedge hclk) begin
        ev_s += events.sleep;
        ev_w += events.watchdog;
        ev_b += events.brk;
    end

    task stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Waits at rising edges until hready is seen high, with a bound.
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                miscompares++;
                stop_test();
            end
            @(posedge hclk);
        end
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        xfer(1'b1, a, d, t);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask

    function automatic logic [31:0] mk(logic [4:0] op, logic [2:0] b, logic [1:0] p, logic [1:0] m, logic [7:0] f);
        cmd_s c;
        c = '{field: f, operand: 8'h00, mode: m, ptr: p, bit_sel: b, op: op};
        return {4'h0, c};
    endfunction

    // Issues a command, checks busy one read later, then polls to completion.
    task run(input logic [31:0] c, input int n);
        logic [31:0] st;
        int k;
        wr(CMD_OFS, c);
        rd(STATUS_OFS, st);
        chk("busy after issue", {31'h0, st[0]}, {31'h0, n > 1});
        for (k = 0; k < 20 && st[0] !== 1'b0; k++) rd(STATUS_OFS, st);
        if (st[0] !== 1'b0) begin
            miscompares++;
            stop_test();
        end
    endtask

    task exec(input logic [7:0] f, input logic [7:0] d, input logic [31:0] c, input int n,
              output logic [7:0] r, output logic [7:0] fo);
        logic [31:0] v;
        wr(FLAGS_OFS, {24'h0, f});
        wr(OPND_OFS, {24'h0, d});
        run(c, n);
        rd(RESULT_OFS, v);
        r = v[7:0];
        rd(FLAGS_OFS, v);
        fo = v[7:0];
    endtask

    // Registers come out of reset at zero; an unmapped place reads zero and keeps no write.
    task t_reset;
        logic [31:0] v;
        int i;
        for (i = 2; i < 8; i++) begin
            rd(8'(4 * i), v);
            chk("reset value", v, 32'h0);
        end
        wr(8'h40, 32'hdeadbeef);
        rd(8'h40, v);
        chk("unmapped read", v, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    // Every shift and rotate, with both carry values and edge operands.
    task t_shift;
        logic [7:0] ds [3];
        logic [7:0] r, fo, e;
        logic co;
        int op, i, c;
        ds = '{8'h81, 8'h40, 8'h01};
        for (op = 3; op < 8; op++) for (i = 0; i < 3; i++) for (c = 0; c < 2; c++) begin
            case (op)
                3: {co, e} = {ds[i], 1'b0};
                4: {e, co} = {1'b0, ds[i]};
                5: {co, e} = {ds[i], c[0]};
                6: {e, co} = {c[0], ds[i]};
                default: {e, co} = {ds[i][7], ds[i]};
            endcase
            exec(8'hf0 | 8'(c), ds[i], mk(5'(op), 3'h0, 2'h0, 2'h0, 8'h0), 1, r, fo);
            chk("shift result", {24'h0, r}, {24'h0, e});
            chk("shift flags", {24'h0, fo}, {24'h0, 4'hf, e[7] ^ co, e[7], e == 8'h0, co});
        end
    endtask

    // Set and clear of each flag, against all-clear and all-set backgrounds.
    task t_flags;
        logic [7:0] r, fo;
        int i;
        for (i = 0; i < 8; i++) begin
            exec(8'h00, 8'h00, mk(OP_FLAG_SET, 3'(i), 2'h0, 2'h0, 8'h0), 1, r, fo);
            chk("flag set", {24'h0, fo}, 32'h1 << i);
            exec(8'hff, 8'h00, mk(OP_FLAG_CLEAR, 3'(i), 2'h0, 2'h0, 8'h0), 1, r, fo);
            chk("flag clear", {24'h0, fo}, {24'h0, ~(8'h1 << i)});
        end
    endtask

    // T capture and deposit in both directions.
    task t_tbit;
        logic [7:0] r, fo;
        exec(8'h00, 8'h08, mk(OP_FLAG_T_CAPTURE, 3'h3, 2'h0, 2'h0, 8'h0), 1, r, fo);
        chk("capture one", {24'h0, fo}, 32'h40);
        exec(8'hff, 8'h08, mk(OP_FLAG_T_CAPTURE, 3'h2, 2'h0, 2'h0, 8'h0), 1, r, fo);
        chk("capture zero", {24'h0, fo}, 32'hbf);
        exec(8'h40, 8'h81, mk(OP_FLAG_T_DEPOSIT, 3'h5, 2'h0, 2'h0, 8'h0), 1, r, fo);
        chk("deposit one", {16'h0, r, fo}, 32'ha140);
        exec(8'h3f, 8'hff, mk(OP_FLAG_T_DEPOSIT, 3'h0, 2'h0, 2'h0, 8'h0), 1, r, fo);
        chk("deposit zero", {16'h0, r, fo}, 32'hfe3f);
    endtask

    // Set and clear of a bit in I/O register 3.
    task t_io;
        logic [31:0] v;
        logic [7:0] r, fo;
        wr(8'hec, 32'h0000a500);
        exec(8'h5a, 8'h00, mk(OP_SET_IO_BIT, 3'h1, 2'h0, 2'h0, 8'h03), 2, r, fo);
        rd(8'hec, v);
        chk("io set", {16'h0, v[15:8], fo}, 32'ha75a);
        exec(8'ha5, 8'h00, mk(OP_CLEAR_IO_BIT, 3'h7, 2'h0, 2'h0, 8'h03), 2, r, fo);
        rd(8'hec, v);
        chk("io clear", {16'h0, v[15:8], fo}, 32'h27a5);
    endtask

    // Loads and stores through every pointer and mode, then offset and direct forms.
    task t_mem;
        logic [31:0] v, m;
        logic [7:0] r, fo, pa;
        int p, a;
        for (a = 0; a < 10; a++) wr(8'(8'h80 + 4 * a), 32'h30 + a);
        for (p = 0; p < 3; p++) begin
            pa = 8'(PTRX_OFS + 4 * p);
            wr(8'h94, 32'h35);
            wr(8'h98, 32'h36);
            wr(pa, 32'h6);
            exec(8'h5a, 8'h00, mk(OP_MEM_READ_INDIRECT, 3'h0, 2'(p), MODE_PRE_DEC, 8'h0), 2, r, fo);
            rd(pa, v);
            chk("load pre-dec", {r, fo, v[15:0]}, 32'h355a0005);
            exec(8'h5a, 8'h00, mk(OP_MEM_READ_INDIRECT, 3'h0, 2'(p), MODE_POST_INC, 8'h0), 2, r, fo);
            rd(pa, v);
            chk("load post-inc", {r, fo, v[15:0]}, 32'h355a0006);
            exec(8'h5a, 8'h00, mk(OP_MEM_READ_INDIRECT, 3'h0, 2'(p), MODE_PLAIN, 8'h0), 2, r, fo);
            rd(pa, v);
            chk("load plain", {r, fo, v[15:0]}, 32'h365a0006);
            exec(8'h5a, 8'hc0, mk(OP_MEM_WRITE_INDIRECT, 3'h0, 2'(p), MODE_PRE_DEC, 8'h0), 2, r, fo);
            rd(8'h94, m);
            rd(pa, v);
            chk("store pre-dec", {m[7:0], fo, v[15:0]}, 32'hc05a0005);
            exec(8'h5a, 8'hd0, mk(OP_MEM_WRITE_INDIRECT, 3'h0, 2'(p), MODE_POST_INC, 8'h0), 2, r, fo);
            rd(8'h94, m);
            rd(pa, v);
            chk("store post-inc", {m[7:0], fo, v[15:0]}, 32'hd05a0006);
            exec(8'h5a, 8'he0, mk(OP_MEM_WRITE_INDIRECT, 3'h0, 2'(p), MODE_PLAIN, 8'h0), 2, r, fo);
            rd(8'h98, m);
            rd(pa, v);
            chk("store plain", {m[7:0], fo, v[15:0]}, 32'he05a0006);
        end
        for (p = 1; p < 3; p++) begin
            pa = 8'(PTRX_OFS + 4 * p);
            wr(pa, 32'h3);
            exec(8'h5a, 8'h00, mk(OP_MEM_READ_OFFSET, 3'h0, 2'(p), 2'h0, 8'h04), 2, r, fo);
            rd(pa, v);
            chk("load offset", {r, fo, v[15:0]}, 32'h375a0003);
            exec(8'h5a, 8'h70 + 8'(p), mk(OP_MEM_WRITE_OFFSET, 3'h0, 2'(p), 2'h0, 8'h05), 2, r, fo);
            rd(8'ha0, m);
            rd(pa, v);
            chk("store offset", {m[7:0], fo, v[15:0]}, {8'h70 + 8'(p), 24'h5a0003});
        end
        exec(8'h5a, 8'h00, mk(OP_MEM_READ_DIRECT, 3'h0, 2'h0, 2'h0, 8'h09), 2, r, fo);
        chk("load direct", {16'h0, r, fo}, 32'h395a);
        exec(8'ha5, 8'h99, mk(OP_MEM_WRITE_DIRECT, 3'h0, 2'h0, 2'h0, 8'h02), 2, r, fo);
        rd(8'h88, m);
        chk("store direct", {16'h0, m[7:0], fo}, 32'h99a5);
    endtask

    // Program memory fetch with and without the Z increment.
    task t_fetch;
        logic [31:0] v;
        logic [7:0] r, fo;
        wr(PTRZ_OFS, 32'h0123);
        exec(8'h5a, 8'h00, mk(OP_PROGRAM_MEMORY_FETCH, 3'h0, PTR_Z, MODE_POST_INC, 8'h0), 3, r, fo);
        rd(PTRZ_OFS, v);
        chk("fetch post-inc", {r, fo, v[15:0]}, {8'h23 ^ 8'h01 ^ 8'h5a, 24'h5a0124});
        chk("fetch address", {16'h0, prog_addr}, 32'h0124);
        exec(8'h5a, 8'h00, mk(OP_PROGRAM_MEMORY_FETCH, 3'h0, PTR_Z, MODE_PLAIN, 8'h0), 3, r, fo);
        rd(PTRZ_OFS, v);
        chk("fetch plain", {r, fo, v[15:0]}, {8'h24 ^ 8'h01 ^ 8'h5a, 24'h5a0124});
    endtask

    // Sleep, watchdog restart and break each give one pulse and keep the flags.
    task t_events;
        logic [7:0] r, fo;
        int s0, w0, b0, k;
        for (k = 0; k < 3; k++) begin
            s0 = ev_s;
            w0 = ev_w;
            b0 = ev_b;
            exec(8'h5a, 8'h00, mk(5'(int'(OP_SLEEP) + k), 3'h0, 2'h0, 2'h0, 8'h0), 1, r, fo);
            chk("event flags", {24'h0, fo}, 32'h5a);
            chk("event pulses", 32'((ev_s - s0) * 4 + (ev_w - w0) * 2 + (ev_b - b0)), 32'h4 >> k);
        end
    endtask

    // Reset for two cycles, then the scenarios in turn.
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_shift();
        t_flags();
        t_tbit();
        t_io();
        t_mem();
        t_fetch();
        t_events();
        stop_test();
    end
endmodule
